/* File: design/dram_ctrl.sv */
// module: host-side controller that runs cycles and refresh on a 4k x 1 dram
// Summary of operation
// - the controller refreshes every stored row at least once each 2 ms.
// - refresh is a read cycle at each of the 64 rows on the six low bits.
// - a refresh cycle works with chip select at either level.
// - during refresh the address stays stable from set-up through hold.
// - every read, write or refresh cycle lasts at least 400 ns.
// - a read-modify-write cycle lasts at least 520 ns.
// - in read-modify-write the write strobe waits until data out is valid.
module dram_ctrl #(
  parameter int REFRESH_GAP = dram_ctrl_pkg::REFRESH_GAP_CYC
) (
  input  wire logic                             clk,
  input  wire logic                             sys_rst,
  // user request side
  input  wire logic                             reqValid,
  input  wire dram_ctrl_pkg::cmd_type           reqCmd,
  input  wire logic [dram_ctrl_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic                             reqData,
  output logic                                  reqReady,
  output logic                                  rspValid,
  output logic                                  rspData,
  // memory pins
  output logic [dram_ctrl_pkg::ADDR_W-1:0]      cellAddress,
  output logic                                  chipEnable,
  output logic                                  chipSelectN,
  output logic                                  writeEnableN,
  output logic                                  dataIn,
  input  wire logic                             dataOut
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    IDLE,
    SETUP,
    STROBE,
    RECOVER
  } phase_type;

  typedef struct packed {
    phase_type                          phase;
    logic [dram_ctrl_pkg::CNT_W-1:0]    count;
    logic [dram_ctrl_pkg::CNT_W-1:0]    total;
    dram_ctrl_pkg::cmd_type             cmd;
    logic                               isRefresh;
    logic                               refreshDue;
    logic [dram_ctrl_pkg::ROW_W-1:0]    row;
    logic [dram_ctrl_pkg::ADDR_W-1:0]   addr;
    logic                               wdata;
    logic                               rdata;
    logic                               ce;
    logic                               csN;
    logic                               weN;
    logic                               din;
    logic                               ready;
    logic                               rspValid;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic      refreshTick;

  localparam logic [dram_ctrl_pkg::CNT_W-1:0] SETUP_C =
    dram_ctrl_pkg::CNT_W'(dram_ctrl_pkg::SETUP_CYC);
  localparam logic [dram_ctrl_pkg::CNT_W-1:0] ON_C =
    dram_ctrl_pkg::CNT_W'(dram_ctrl_pkg::STROBE_ON_CYC);
  localparam logic [dram_ctrl_pkg::CNT_W-1:0] ON_RMW_C =
    dram_ctrl_pkg::CNT_W'(dram_ctrl_pkg::STROBE_RMW_CYC);
  localparam logic [dram_ctrl_pkg::CNT_W-1:0] OFF_C =
    dram_ctrl_pkg::CNT_W'(dram_ctrl_pkg::STROBE_OFF_CYC);
  localparam logic [dram_ctrl_pkg::CNT_W-1:0] HOLD_C =
    dram_ctrl_pkg::CNT_W'(dram_ctrl_pkg::HOLD_CYC);
  localparam logic [dram_ctrl_pkg::CNT_W-1:0] SAMPLE_C =
    dram_ctrl_pkg::CNT_W'(dram_ctrl_pkg::SAMPLE_CYC);
  localparam logic [dram_ctrl_pkg::CNT_W-1:0] WOFF_C =
    dram_ctrl_pkg::CNT_W'(dram_ctrl_pkg::WRITE_OFF_CYC);
  localparam logic [dram_ctrl_pkg::CNT_W-1:0] CYC_C =
    dram_ctrl_pkg::CNT_W'(dram_ctrl_pkg::CYCLE_CYC);
  localparam logic [dram_ctrl_pkg::CNT_W-1:0] RMW_C =
    dram_ctrl_pkg::CNT_W'(dram_ctrl_pkg::RMW_CYCLE_CYC);

  // ****************************************
  // refresh pacing
  // ****************************************
  // one tick per row slot so 64 rows fit inside the interval
  interval_timer #(
    .WIDTH  (dram_ctrl_pkg::CNT_W),
    .PERIOD (REFRESH_GAP)
  ) u_refresh_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .restart (1'b0),
    .tick    (refreshTick)
  );

  // ****************************************
  // cycle sequencer
  // ****************************************
  // each cycle: address set-up, strobe on, strobe off recovery
  always_comb begin
    s_d = s_q;
    s_d.rspValid = 1'b0;
    s_d.count = s_q.count + dram_ctrl_pkg::CNT_W'(1);
    s_d.total = s_q.total + dram_ctrl_pkg::CNT_W'(1);
    if (refreshTick) begin
      s_d.refreshDue = 1'b1;
    end
    case (s_q.phase)
      IDLE: begin
        s_d.count = '0;
        s_d.total = '0;
        if (reqValid && s_q.ready) begin
          // ready high is a promise: a request seen with it is taken
          s_d.isRefresh = 1'b0;
          s_d.cmd       = reqCmd;
          s_d.addr      = reqAddr;
          s_d.wdata     = reqData;
          s_d.csN       = 1'b0;
          s_d.ready     = 1'b0;
          s_d.phase     = SETUP;
        end else if (s_q.refreshDue || refreshTick) begin
          // a pending refresh has already dropped ready, so no starvation
          s_d.isRefresh  = 1'b1;
          s_d.refreshDue = 1'b0;
          s_d.cmd        = dram_ctrl_pkg::CMD_READ;
          s_d.addr       = {{(dram_ctrl_pkg::ADDR_W -
                            dram_ctrl_pkg::ROW_W){1'b0}}, s_q.row};
          s_d.row        = s_q.row + dram_ctrl_pkg::ROW_W'(1);
          s_d.csN        = 1'b1;
          s_d.ready      = 1'b0;
          s_d.phase      = SETUP;
        end else begin
          s_d.ready = 1'b1;
        end
      end
      SETUP: begin
        // address is stable before the strobe rises
        if (s_q.count + dram_ctrl_pkg::CNT_W'(1) >= SETUP_C) begin
          s_d.ce    = 1'b1;
          s_d.count = '0;
          s_d.phase = STROBE;
          if (s_q.cmd == dram_ctrl_pkg::CMD_WRITE) begin
            s_d.din = s_q.wdata;
            s_d.weN = 1'b0;
          end
        end
      end
      STROBE: begin
        // sample read data once access time from address has passed
        if (s_q.cmd != dram_ctrl_pkg::CMD_WRITE &&
            s_q.total == SAMPLE_C) begin
          s_d.rdata = ~dataOut;
        end
        // rmw: write strobe only after output delay elapsed
        if (s_q.cmd == dram_ctrl_pkg::CMD_RMW &&
            s_q.total == SAMPLE_C) begin
          s_d.din = s_q.wdata;
          s_d.weN = 1'b0;
        end
        if ((s_q.cmd == dram_ctrl_pkg::CMD_RMW) ?
            (s_q.count + dram_ctrl_pkg::CNT_W'(1) >= ON_RMW_C &&
             s_q.count + dram_ctrl_pkg::CNT_W'(1) >= WOFF_C +
             SAMPLE_C - SETUP_C) :
            (s_q.count + dram_ctrl_pkg::CNT_W'(1) >= ON_C)) begin
          s_d.ce    = 1'b0;
          s_d.count = '0;
          s_d.phase = RECOVER;
          s_d.rspValid = ~s_q.isRefresh;
        end
      end
      RECOVER: begin
        // keep address and select through the hold period
        if (s_q.count + dram_ctrl_pkg::CNT_W'(1) >= HOLD_C) begin
          s_d.weN = 1'b1;
        end
        // strobe-off time and full cycle length both satisfied
        if (s_q.count + dram_ctrl_pkg::CNT_W'(1) >= OFF_C &&
            s_q.count >= HOLD_C &&
            s_q.total + dram_ctrl_pkg::CNT_W'(1) >=
            ((s_q.cmd == dram_ctrl_pkg::CMD_RMW) ? RMW_C : CYC_C)) begin
          s_d.csN   = 1'b1;
          s_d.ready = ~s_d.refreshDue;  // pending refresh runs next
          s_d.phase = IDLE;
        end
      end
      default: begin
        s_d.phase = IDLE;
      end
    endcase
  end

  // register the state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q       <= '0;
      s_q.phase <= IDLE;
      s_q.csN   <= 1'b1;
      s_q.weN   <= 1'b1;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs, all from flip-flops
  // ****************************************
  assign reqReady     = s_q.ready;
  assign rspValid     = s_q.rspValid;
  assign rspData      = s_q.rdata;
  assign cellAddress  = s_q.addr;
  assign chipEnable   = s_q.ce;
  assign chipSelectN  = s_q.csN;
  assign writeEnableN = s_q.weN;
  assign dataIn       = s_q.din;

endmodule

/* File: design/dram_ctrl_pkg.sv */
// package: timing constants and commands for the 4k x 1 dynamic memory controller
package dram_ctrl_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int ADDR_W    = 12;   // 4096 words
  localparam int ROW_W     = 6;    // refresh rows on the low address bits
  localparam int ROW_COUNT = 64;

  // ****************************************
  // timing in ns and in 10 ns cycles
  // ****************************************
  localparam int CLK_NS              = 10;
  localparam int REFRESH_PERIOD_NS   = 2000000;  // whole refresh interval
  localparam int CYCLE_NS            = 400;
  localparam int RMW_CYCLE_NS        = 520;
  localparam int STROBE_ON_NS        = 230;
  localparam int STROBE_ON_RMW_NS    = 350;
  localparam int STROBE_OFF_NS       = 130;
  localparam int ACCESS_NS           = 200;
  localparam int STROBE_TO_OUT_NS    = 180;
  localparam int WRITE_TO_OFF_NS     = 150;
  localparam int DATA_SETUP_NS       = 150;
  localparam int ADDRESS_SETUP_NS    = 0;
  localparam int ADDRESS_HOLD_NS     = 50;

  // least times round up, at least one cycle
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CYCLE_CYC        = ceil_cyc(CYCLE_NS);
  localparam int RMW_CYCLE_CYC    = ceil_cyc(RMW_CYCLE_NS);
  localparam int STROBE_ON_CYC    = ceil_cyc(STROBE_ON_NS);
  localparam int STROBE_RMW_CYC   = ceil_cyc(STROBE_ON_RMW_NS);
  localparam int STROBE_OFF_CYC   = ceil_cyc(STROBE_OFF_NS);
  localparam int SETUP_CYC        = ceil_cyc(ADDRESS_SETUP_NS);
  localparam int HOLD_CYC         = ceil_cyc(ADDRESS_HOLD_NS);
  localparam int SAMPLE_CYC       = ceil_cyc(ACCESS_NS);
  localparam int WRITE_OFF_CYC    = ceil_cyc(WRITE_TO_OFF_NS);
  // refresh: 64 rows spread over the interval, with one read-modify-write cycle of margin
  localparam int REFRESH_GAP_CYC  =
    REFRESH_PERIOD_NS / CLK_NS / ROW_COUNT - RMW_CYCLE_CYC;

  // ****************************************
  // commands
  // ****************************************
  typedef enum logic [1:0] {
    CMD_READ  = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_RMW   = 2'h2
  } cmd_type;

  localparam int CNT_W = 16;

endpackage

/* File: design/interval_timer.sv */
// module: down counter that pulses once every load value plus one cycles
module interval_timer #(
  parameter int          WIDTH  = 16,
  parameter int unsigned PERIOD = 100
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic restart,
  output logic      tick
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             tick;
  } state_type;

  state_type s_q;
  state_type s_d;

  // count down, pulse at zero and reload
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart || s_q.count == '0) begin
      s_d.count = WIDTH'(PERIOD);
      s_d.tick  = ~restart;
    end else begin
      s_d.count = s_q.count - WIDTH'(1);
    end
  end

  // register the state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

/* File: sim/dram_cell_model.sv */
// partner: behavioural 4k x 1 dynamic memory on the controller's pins
module dram_cell_model (
  input  wire logic        clk,
  input  wire logic [11:0] cellAddress,
  input  wire logic        chipEnable,
  input  wire logic        chipSelectN,
  input  wire logic        writeEnableN,
  input  wire logic        dataIn,
  output logic             dataOut
);
  timeunit 1ns;
  timeprecision 100ps;
  logic memArray [4096];
  int   onCnt = 0;
  logic floatVal = 1'b0;
  initial begin
    foreach (memArray[i]) memArray[i] = 1'b0;
  end
  // refresh is a plain read, chip select not needed; writes need select
  always @(posedge clk) begin
    onCnt <= chipEnable ? onCnt + 1 : 0;
    if (chipEnable && !chipSelectN && !writeEnableN) begin
      memArray[cellAddress] <= dataIn;
    end
    floatVal <= ~dataOut; // floating output shows no stale value
  end
  // inverted data, valid late in the strobe, floats once strobe drops
  assign dataOut = (chipEnable && !chipSelectN && onCnt >= 18) ?
                   ~memArray[cellAddress] : floatVal;
endmodule

/* File: sim/dram_ctrl_properties.sv */
// checker: timing relations on the memory pins of the controller
module dram_ctrl_properties (
  input wire logic                             clk,
  input wire logic                             sys_rst,
  input wire logic                             chipEnable,
  input wire logic                             chipSelectN,
  input wire logic                             writeEnableN,
  input wire logic [dram_ctrl_pkg::ADDR_W-1:0] cellAddress
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [9:0] since_q, on_q, off_q, we_q;
  logic       rmw_q;
  function automatic logic [9:0] inc(input logic [9:0] v);
    return (v == 10'h3ff) ? v : v + 10'h1;
  endfunction
  // cycle, strobe, off-time and write counters
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_q <= 10'h3ff;
      on_q    <= 10'h0;
      off_q   <= 10'h3ff;
      we_q    <= 10'h0;
      rmw_q   <= 1'b0;
    end else begin
      since_q <= $rose(chipEnable) ? 10'h1 : inc(since_q);
      on_q    <= chipEnable ? inc(on_q) : 10'h0;
      off_q   <= chipEnable ? 10'h0 : inc(off_q);
      we_q    <= writeEnableN ? 10'h0 : (chipEnable ? inc(we_q) : we_q);
      if ($rose(chipEnable)) rmw_q <= 1'b0;
      else if ($fell(writeEnableN) && chipEnable) rmw_q <= 1'b1;
    end
  end
  cycle_len_a: assert property ($rose(chipEnable) |->
    since_q >= dram_ctrl_pkg::CYCLE_CYC) else $error("cycle too short");
  strobe_width_a: assert property ($fell(chipEnable) |->
    on_q >= dram_ctrl_pkg::STROBE_ON_CYC) else $error("strobe too short");
  off_time_a: assert property ($rose(chipEnable) |->
    off_q >= dram_ctrl_pkg::STROBE_OFF_CYC) else $error("off time short");
  rmw_cycle_a: assert property ($rose(chipEnable) && rmw_q |->
    since_q >= dram_ctrl_pkg::RMW_CYCLE_CYC) else $error("rmw cycle short");
  rmw_strobe_a: assert property ($fell(chipEnable) && rmw_q |->
    on_q >= dram_ctrl_pkg::STROBE_RMW_CYC) else $error("rmw strobe short");
  we_late_a: assert property ($fell(writeEnableN) && chipEnable &&
    !$rose(chipEnable) |->
    on_q >= dram_ctrl_pkg::STROBE_TO_OUT_NS / dram_ctrl_pkg::CLK_NS)
    else $error("write too early");
  write_off_a: assert property ($fell(chipEnable) && !writeEnableN |->
    we_q >= dram_ctrl_pkg::WRITE_OFF_CYC) else $error("write too short");
  addr_hold_a: assert property ($rose(chipEnable) |->
    $stable(cellAddress) [*6]) else $error("address moved");
  refresh_row_a: assert property ($rose(chipEnable) && chipSelectN |->
    cellAddress[11:6] == 6'h0) else $error("refresh row high bits");
endmodule
bind dram_ctrl dram_ctrl_properties chk_u (.clk(clk), .sys_rst(sys_rst),
  .chipEnable(chipEnable), .chipSelectN(chipSelectN),
  .writeEnableN(writeEnableN), .cellAddress(cellAddress));

/* File: sim/dram_ctrl_tb_top.sv */
// testbench: random and corner accesses with refresh watching
module dram_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int GAP = 200;
  logic clk = 0, sys_rst = 1, reqValid = 0, reqData = 0, dataOut;
  dram_ctrl_pkg::cmd_type reqCmd = dram_ctrl_pkg::CMD_READ;
  logic [11:0] reqAddr = 12'h0, cellAddress, row = 12'h0;
  logic reqReady, rspValid, rspData, chipEnable, chipSelectN;
  logic writeEnableN, dataIn, prevCe = 0, q;
  logic [15:0] rnd = 16'h33;
  logic shadow [4096];
  int err_count = 0, compares = 0, gapCnt = 0, refCnt = 0;
  always #5 clk = ~clk;
  dram_ctrl #(.REFRESH_GAP(GAP)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .reqValid(reqValid), .reqCmd(reqCmd), .reqAddr(reqAddr),
    .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .cellAddress(cellAddress), .chipEnable(chipEnable),
    .chipSelectN(chipSelectN), .writeEnableN(writeEnableN),
    .dataIn(dataIn), .dataOut(dataOut));
  dram_cell_model mem_u (.clk(clk), .cellAddress(cellAddress),
    .chipEnable(chipEnable), .chipSelectN(chipSelectN),
    .writeEnableN(writeEnableN), .dataIn(dataIn), .dataOut(dataOut));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string name, input logic [11:0] e,
                     input logic [11:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one request held until taken, then wait for its response
  task automatic access(input dram_ctrl_pkg::cmd_type c,
                        input logic [11:0] a, input logic d);
    int i;
    i = 0;
    reqCmd = c;
    reqAddr = a;
    reqData = d;
    reqValid = 1'b1;
    do begin @(posedge clk); i++; end while (reqReady !== 1'b1 && i < 3000);
    #1 reqValid = 1'b0;
    do begin @(posedge clk); #1; i++; end
    while (rspValid !== 1'b1 && i < 6000);
    if (i >= 6000) begin err_count++; summarize(); end
    if (c != dram_ctrl_pkg::CMD_WRITE) chk("read data", shadow[a], rspData);
    if (c != dram_ctrl_pkg::CMD_READ) shadow[a] = d;
  endtask
  // refresh strobes walk the rows in order with bounded spacing
  always @(posedge clk) begin
    prevCe <= chipEnable;
    gapCnt <= gapCnt + 1;
    if (chipEnable && !prevCe && chipSelectN) begin
      chk("refresh row", row, cellAddress);
      chk("refresh gap", 12'h1, 12'(gapCnt <= GAP + 100));
      row <= {6'h0, row[5:0] + 6'h1};
      gapCnt <= 0;
      refCnt <= refCnt + 1;
    end
  end
  initial begin
    foreach (shadow[i]) shadow[i] = 1'b0;
    repeat (6) @(posedge clk);
    #1 sys_rst = 0;
    access(dram_ctrl_pkg::CMD_WRITE, 12'h000, 1'b1);
    access(dram_ctrl_pkg::CMD_WRITE, 12'hfff, 1'b0);
    access(dram_ctrl_pkg::CMD_RMW, 12'hfff, 1'b1);
    access(dram_ctrl_pkg::CMD_READ, 12'h000, 1'b0);
    access(dram_ctrl_pkg::CMD_READ, 12'hfff, 1'b0);
    $display("test corners done");
    for (int n = 0; n < 60; n++) begin
      rnd = lfsr(rnd);
      access(dram_ctrl_pkg::cmd_type'(rnd[1:0] % 3), rnd[15:4], rnd[2]);
    end
    $display("test random done");
    repeat (64 * (GAP + 20)) @(posedge clk);
    chk("refresh count", 12'h1, 12'(refCnt >= 64));
    $display("test refresh done");
    summarize();
  end
endmodule
